// ### fpu_map.vh
`ifndef FPU_MAP_VH
`define FPU_MAP_VH
// register byte offsets
`define FPU_CTRL_OFS 8'h00
`define FPU_KEY_OFS 8'h04
`define FPU_STAT_OFS 8'h08
`define FPU_OPT_OFS 8'h0c
// control register fields
`define FPU_CTRL_RELOCK_BIT 0
// status register fields
`define FPU_STAT_UNLOCK_BIT 0
`define FPU_STAT_LOCKOUT_BIT 1
`define FPU_STAT_ERASE_BIT 2
`define FPU_STAT_OPTERR_BIT 3
`define FPU_STAT_REJ_BIT 4
// unlock keys, written one after the other
`define FPU_KEY1 8'hae
`define FPU_KEY2 8'h56
// readout lock inactive value
`define FPU_LOCK_OFF 8'haa
// boot region granule: 512 bytes
`define FPU_GRAN_SHIFT 9
// unlock lifetime in cycles
`define FPU_UNLOCK_CYC 16'h0400
// axi responses
`define FPU_RESP_OKAY 2'b00
`define FPU_RESP_SLVERR 2'b10
`endif

// ### fpu_top.v
`timescale 1ns/1ps
`include "fpu_map.vh"
// Overview of operation
// - app writes blocked until key sequence; unlock expires after a fixed time
// - boot region up to 128 Kbytes, set by option bytes, never overwritten
// - boot region size changeable only over debug port, app attempts ignored
// - region starts at vector base, size in 512-byte steps from byte and inverse
// - readout lock active when its option byte holds any value but the off setting
// - while locked, all debug reads and writes of memories and options refused, except the write that removes the lock
// - readout lock applies in every mode, no bypass
// - removing readout lock first erases whole program and data memory
// - options kept as true and inverse copies; lock byte and 8..16 single
module fpu_top #(
    parameter AW = 17,
    parameter UNLOCK_CYC = `FPU_UNLOCK_CYC
) (
    input wire clock,
    input wire rstn,
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // stored option bytes, loaded from the option block, and the operating mode input
    input wire [7:0] readout_lock,
    input wire [7:0] boot_region_size,
    input wire [7:0] boot_region_size_inverse,
    input wire in_circuit_programming,
    // cpu flash write requests
    input wire cpu_wr_req,
    input wire [AW-1:0] cpu_wr_addr,
    output reg cpu_wr_grant,
    output reg cpu_wr_reject,
    // debug port access requests
    input wire dbg_req,
    input wire dbg_wr,
    input wire dbg_opt_sel,
    input wire [7:0] dbg_opt_addr,
    input wire [7:0] dbg_opt_data,
    output reg dbg_grant,
    output reg dbg_refuse,
    // option programming and mass erase towards flash controller
    output reg opt_wr_stb,
    output reg [7:0] opt_wr_addr,
    output reg [7:0] opt_wr_data,
    output reg erase_req,
    input wire erase_done
);
// ----------------------------------------
// option decode
// ----------------------------------------
localparam [7:0] ADDR_LOCK = 8'h00;
localparam [7:0] ADDR_BOOT = 8'h01;
localparam [7:0] ADDR_BOOTN = 8'h02;

// boot option valid only when copies agree; mismatch treated as full size
function [AW:0] boundary_of;
    input [7:0] sz;
    input [7:0] szn;
    begin
        // size of zero leaves no boot region at all
        if (sz == ~szn)
            boundary_of = {{(AW-8){1'b0}}, sz, 1'b0} << (`FPU_GRAN_SHIFT - 1);
        else
            boundary_of = {1'b1, {AW{1'b0}}};
    end
endfunction

wire opt_pair_ok = (boot_region_size == ~boot_region_size_inverse);
wire [AW:0] boundary = boundary_of(boot_region_size, boot_region_size_inverse);
// no mode input gates this: lock holds regardless of operating mode
// any value but the off code locks, so a corrupted byte fails safe
wire lock_on = (readout_lock != `FPU_LOCK_OFF);

// ----------------------------------------
// registers and state
// ----------------------------------------
reg unlock_q;
reg [15:0] unlock_cnt_q;
reg key_stage_q;
reg rej_q;
reg erase_q;
reg [7:0] pend_data_q;
reg [7:0] pend_addr_q;
reg aw_hold_q;
reg w_hold_q;
reg [7:0] aw_addr_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;

wire wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
wire key_wr = wr_go && (aw_addr_q == `FPU_KEY_OFS) && w_strb_q[0];
wire ctrl_wr = wr_go && (aw_addr_q == `FPU_CTRL_OFS) && w_strb_q[0];
wire wr_mapped = (aw_addr_q == `FPU_CTRL_OFS) || (aw_addr_q == `FPU_KEY_OFS) ||
    (aw_addr_q == `FPU_STAT_OFS) || (aw_addr_q == `FPU_OPT_OFS);
wire clr_stat = wr_go && (aw_addr_q == `FPU_STAT_OFS) && w_strb_q[0] &&
    w_data_q[`FPU_STAT_REJ_BIT];

// flash write inside boot region rejected; outside needs unlock
// limitation: a mismatched option pair protects the whole array
wire in_boot = ({1'b0, cpu_wr_addr} < boundary);
wire cpu_wr_grant_d = cpu_wr_req && unlock_q && !in_boot && !erase_q;
// reject is the exact complement of grant for a live request
wire rej_set = cpu_wr_req && !cpu_wr_grant_d;

// ----------------------------------------
// axi write channel
// ----------------------------------------
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        aw_addr_q <= 8'h00;
        w_data_q <= 32'h0;
        w_strb_q <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `FPU_RESP_OKAY;
    end else begin
        // ready pulses once per item; the master holds valid until it sees it
        s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
        s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
        if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // option register is read-only to software
            s_axi_bresp <= (wr_mapped && aw_addr_q != `FPU_OPT_OFS) ?
                `FPU_RESP_OKAY : `FPU_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------
// axi read channel
// ----------------------------------------
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `FPU_RESP_OKAY;
    end else begin
        // address decoded at the handshake edge, so araddr must still stand
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `FPU_RESP_OKAY;
            case (s_axi_araddr)
                `FPU_CTRL_OFS: s_axi_rdata <= 32'h0;
                `FPU_KEY_OFS: s_axi_rdata <= 32'h0;
                `FPU_STAT_OFS: s_axi_rdata <= {27'h0, rej_q, !opt_pair_ok, erase_q,
                    lock_on, unlock_q};
                `FPU_OPT_OFS: s_axi_rdata <= {8'h00, boot_region_size_inverse,
                    boot_region_size, readout_lock};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `FPU_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// ----------------------------------------
// unlock sequence and timeout
// ----------------------------------------
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        unlock_q <= 1'b0;
        unlock_cnt_q <= 16'h0;
        key_stage_q <= 1'b0;
    end else begin
        if (key_wr) begin
            // wrong key restarts the sequence and drops any open unlock
            if (!key_stage_q && w_data_q[7:0] == `FPU_KEY1) begin
                key_stage_q <= 1'b1;
            end else if (key_stage_q && w_data_q[7:0] == `FPU_KEY2) begin
                key_stage_q <= 1'b0;
                unlock_q <= 1'b1;
                unlock_cnt_q <= UNLOCK_CYC[15:0];
            end else begin
                key_stage_q <= 1'b0;
                unlock_q <= 1'b0;
            end
        end else if (ctrl_wr && w_data_q[`FPU_CTRL_RELOCK_BIT]) begin
            // relock cancels the remaining lifetime at once
            unlock_q <= 1'b0;
        end else if (unlock_q) begin
            if (unlock_cnt_q == 16'h1)
                unlock_q <= 1'b0;
            unlock_cnt_q <= unlock_cnt_q - 16'h1;
        end
    end
end

// ----------------------------------------
// cpu write gate
// ----------------------------------------
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        cpu_wr_grant <= 1'b0;
        cpu_wr_reject <= 1'b0;
        rej_q <= 1'b0;
    end else begin
        // grant and reject are exclusive pulses, one cycle after the request
        cpu_wr_grant <= cpu_wr_grant_d;
        cpu_wr_reject <= rej_set;
        // set beats clear
        if (rej_set)
            rej_q <= 1'b1;
        else if (clr_stat)
            rej_q <= 1'b0;
    end
end

// ----------------------------------------
// debug port access and option writes
// ----------------------------------------
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        dbg_grant <= 1'b0;
        dbg_refuse <= 1'b0;
        opt_wr_stb <= 1'b0;
        opt_wr_addr <= 8'h00;
        opt_wr_data <= 8'h00;
        erase_req <= 1'b0;
        erase_q <= 1'b0;
        pend_addr_q <= 8'h00;
        pend_data_q <= 8'h00;
    end else begin
        dbg_grant <= 1'b0;
        dbg_refuse <= 1'b0;
        opt_wr_stb <= 1'b0;
        if (erase_q) begin
            // option write held back until erase completes
            if (erase_done) begin
                erase_q <= 1'b0;
                erase_req <= 1'b0;
                opt_wr_stb <= 1'b1;
                opt_wr_addr <= pend_addr_q;
                opt_wr_data <= pend_data_q;
            end
            // all other debug traffic is refused until the erase completes
            if (dbg_req)
                dbg_refuse <= 1'b1;
        end else if (dbg_req) begin
            // lock removal passes while locked; the option lands only after the erase
            if (dbg_wr && dbg_opt_sel && dbg_opt_addr == ADDR_LOCK && lock_on &&
                dbg_opt_data == `FPU_LOCK_OFF) begin
                erase_q <= 1'b1;
                erase_req <= 1'b1;
                pend_addr_q <= dbg_opt_addr;
                pend_data_q <= dbg_opt_data;
                dbg_grant <= 1'b1;
            end else if (lock_on) begin
                dbg_refuse <= 1'b1;
            end else if (dbg_wr && dbg_opt_sel && !in_circuit_programming &&
                (dbg_opt_addr == ADDR_LOCK || dbg_opt_addr == ADDR_BOOT ||
                dbg_opt_addr == ADDR_BOOTN)) begin
                dbg_refuse <= 1'b1;
            end else begin
                dbg_grant <= 1'b1;
                if (dbg_wr && dbg_opt_sel) begin
                    opt_wr_stb <= 1'b1;
                    opt_wr_addr <= dbg_opt_addr;
                    opt_wr_data <= dbg_opt_data;
                end
            end
        end
    end
end

endmodule

// ### fpu_assertions.sv
`timescale 1ns/1ps
module fpu_assertions (
    input wire clock,
    input wire rstn,
    input wire [7:0] readout_lock,
    input wire [7:0] boot_region_size,
    input wire [7:0] boot_region_size_inverse,
    input wire in_circuit_programming,
    input wire cpu_wr_req,
    input wire [16:0] cpu_wr_addr,
    input wire cpu_wr_grant,
    input wire cpu_wr_reject,
    input wire dbg_req,
    input wire dbg_opt_sel,
    input wire dbg_grant,
    input wire dbg_refuse,
    input wire opt_wr_stb,
    input wire [7:0] opt_wr_addr,
    input wire erase_req,
    input wire erase_done
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_cpu_one_ans: assert property (cpu_wr_req |=> cpu_wr_grant != cpu_wr_reject)
        else $error("cpu answer");
    a_boot_no_wr: assert property (cpu_wr_req &&
        (cpu_wr_addr >> 9) < boot_region_size |=> !cpu_wr_grant) else $error("boot write");
    a_pair_bad_rej: assert property (cpu_wr_req &&
        boot_region_size != ~boot_region_size_inverse |=> cpu_wr_reject) else $error("pair");
    a_dbg_one_ans: assert property (dbg_req |=> dbg_grant != dbg_refuse)
        else $error("dbg answer");
    a_lock_refuse: assert property (dbg_req && !dbg_opt_sel &&
        readout_lock != 8'haa |=> dbg_refuse) else $error("lock");
    a_erase_refuse: assert property (dbg_req && erase_req |=> dbg_refuse)
        else $error("erase busy");
    a_erase_first: assert property (opt_wr_stb && opt_wr_addr == 8'h00 &&
        readout_lock != 8'haa |-> $past(erase_done)) else $error("no erase");
    a_opt_icp_only: assert property (opt_wr_stb && opt_wr_addr <= 8'h02
        |-> in_circuit_programming) else $error("opt mode");
endmodule
bind fpu_top fpu_assertions fpu_assertions_i (.*);

// ### fpu_dbg_host.sv
`timescale 1ns/1ps
module fpu_dbg_host (
    input wire clock,
    input wire dbg_grant,
    output reg dbg_req,
    output reg dbg_wr,
    output reg dbg_opt_sel,
    output reg [7:0] dbg_opt_addr,
    output reg [7:0] dbg_opt_data,
    output reg in_circuit_programming
);
    initial {dbg_req, dbg_wr, dbg_opt_sel, dbg_opt_addr, dbg_opt_data, in_circuit_programming}
        = 20'h0;
    // refusal reads as grant low; the checker keeps grant and refuse exclusive
    task access(input m, input w, input s, input [7:0] a, input [7:0] d, output g);
        @(posedge clock);
        {in_circuit_programming, dbg_req, dbg_wr, dbg_opt_sel} <= {m, 1'b1, w, s};
        {dbg_opt_addr, dbg_opt_data} <= {a, d};
        @(posedge clock);
        dbg_req <= 1'b0;
        dbg_opt_data <= ~d; // released byte never shows the last value
        @(posedge clock);
        g = dbg_grant;
    endtask
endmodule

// ### fpu_tb.sv
`timescale 1ns/1ps
`include "fpu_map.vh"
module tb;
    reg clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg cpu_wr_req, erase_done, g;
    reg [7:0] s_axi_awaddr, s_axi_araddr, readout_lock, boot_region_size;
    reg [7:0] boot_region_size_inverse;
    reg [31:0] s_axi_wdata, got;
    reg [16:0] cpu_wr_addr;
    reg [1:0] resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire cpu_wr_grant, cpu_wr_reject, dbg_req, dbg_wr, dbg_opt_sel, dbg_grant, dbg_refuse;
    wire opt_wr_stb, erase_req, in_circuit_programming;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [3:0] s_axi_wstrb = 4'hf;
    wire [7:0] dbg_opt_addr, dbg_opt_data, opt_wr_addr, opt_wr_data;
    wire [31:0] s_axi_rdata;
    integer miscompares, cmp_count;
    fpu_top #(.UNLOCK_CYC(32)) fpu_top_i (.*);
    fpu_dbg_host fpu_dbg_host_i (.*);
    task summarize;
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input [31:0] a, input [31:0] e);
        cmp_count = cmp_count + 1;
        if (a !== e) begin
            miscompares = miscompares + 1;
            $display("BAD %0t got %h exp %h", $time, a, e);
        end
    endtask
    // a wait that runs out counts as a mismatch and ends the run
    task guard(input integer n);
        if (n >= 50) begin
            chk(32'h0, 32'h1);
            summarize;
        end
    endtask
    task axi_wr(input [7:0] a, input [31:0] d);
        integer n;
        @(posedge clock);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        n = 0;
        while (!s_axi_bvalid && n < 50) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n = n + 1;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        guard(n);
    endtask
    task axi_rd(input [7:0] a);
        integer n;
        @(posedge clock);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        n = 0;
        while (!s_axi_rvalid && n < 50) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n = n + 1;
        end
        {got, resp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        guard(n);
    endtask
    task cpu(input [16:0] a, input e);
        @(posedge clock);
        {cpu_wr_req, cpu_wr_addr} <= {1'b1, a};
        @(posedge clock);
        cpu_wr_req <= 1'b0;
        @(posedge clock);
        chk({30'h0, cpu_wr_grant, cpu_wr_reject}, {30'h0, e, !e});
    endtask
    task unlock;
        axi_wr(`FPU_KEY_OFS, {24'h0, `FPU_KEY1});
        axi_wr(`FPU_KEY_OFS, {24'h0, `FPU_KEY2});
    endtask
    task dbg(input m, input w, input s, input [7:0] a, input [7:0] d, input [1:0] e);
        fpu_dbg_host_i.access(m, w, s, a, d, g);
        chk({29'h0, g, dbg_refuse, erase_req}, {29'h0, e[1], !e[1], e[0]});
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        {miscompares, cmp_count} = 64'h0;
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {cpu_wr_req, erase_done, s_axi_awaddr, s_axi_araddr, s_axi_wdata, cpu_wr_addr} = 67'h0;
        {readout_lock, boot_region_size, boot_region_size_inverse} = 24'haa04fb;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        axi_rd(`FPU_STAT_OFS);
        chk(got, 32'h0);
        cpu(17'h01000, 1'b0);
        unlock;
        axi_rd(`FPU_STAT_OFS);
        chk(got, 32'h11);
        cpu(17'h007ff, 1'b0);
        cpu(17'h00800, 1'b1);
        repeat (40) @(posedge clock);
        cpu(17'h01000, 1'b0);
        unlock;
        axi_wr(`FPU_CTRL_OFS, 32'h1);
        cpu(17'h01000, 1'b0);
        axi_wr(`FPU_OPT_OFS, 32'h0);
        chk({30'h0, resp}, {30'h0, `FPU_RESP_SLVERR});
        axi_rd(`FPU_OPT_OFS);
        chk(got, 32'h00fb04aa);
        axi_rd(8'h10);
        chk({30'h0, resp}, {30'h0, `FPU_RESP_SLVERR});
        axi_wr(`FPU_STAT_OFS, 32'h10);
        chk({30'h0, resp}, {30'h0, `FPU_RESP_OKAY});
        axi_rd(`FPU_STAT_OFS);
        chk(got, 32'h0);
        boot_region_size_inverse <= 8'h00;
        unlock;
        cpu(17'h1f000, 1'b0);
        boot_region_size_inverse <= 8'hfb;
        dbg(1'b0, 1'b1, 1'b1, 8'h01, 8'h02, 2'h0);
        dbg(1'b1, 1'b1, 1'b1, 8'h01, 8'h02, 2'h2);
        readout_lock <= 8'h00;
        dbg(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 2'h0);
        dbg(1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 2'h0);
        dbg(1'b1, 1'b1, 1'b1, 8'h02, 8'h04, 2'h0);
        dbg(1'b1, 1'b1, 1'b1, 8'h00, `FPU_LOCK_OFF, 2'h3);
        dbg(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 2'h1);
        erase_done <= 1'b1;
        @(posedge clock);
        erase_done <= 1'b0;
        @(posedge clock);
        chk({15'h0, opt_wr_stb, opt_wr_addr, opt_wr_data}, 32'h100aa);
        summarize;
    end
endmodule
